// ===== rtl/dac_buffer_control.sv
// Control for a 10-bit converter: output data, staging buffer, request and flags.
// Assumes start events are one-cycle pulses on sys_clk_i; sync-ready comes from
// another domain and is synchronised here.
`timescale 1ns/100ps
`default_nettype none
module dac_buffer_control #(
  parameter int DATA_W = dac_ctrl_pkg::DATA_W,
  parameter int DEPTH  = dac_ctrl_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  // Control
  input  wire logic              enable_i,
  input  wire logic              write_protect_i,
  input  wire logic              buffer_protect_bypass_i,
  input  wire logic [1:0]        reference_select_i,
  input  wire logic              reference_select_we_i,
  // Processor data write
  input  wire logic              cpu_data_we_i,
  input  wire logic [DATA_W-1:0] cpu_data_i,
  // Staging buffer write (processor or DMA)
  input  wire logic              buf_valid_i,
  output logic                   buf_ready_o,
  input  wire logic [DATA_W-1:0] buf_data_i,
  // DMA direct data write
  input  wire logic              dma_data_we_i,
  input  wire logic [DATA_W-1:0] dma_data_i,
  // Events
  input  wire logic              start_event_i,
  input  wire logic              sync_ready_async_i,
  // Interrupt registers
  input  wire logic [2:0]        irq_flag_clear_i,
  input  wire logic [2:0]        irq_enable_set_i,
  input  wire logic [2:0]        irq_enable_clear_i,
  output logic      [2:0]        irq_flag_reg_o,
  output logic      [2:0]        irq_enable_reg_o,
  output logic                   irq_o,
  // Converter side
  output logic      [DATA_W-1:0] data_o,
  output logic                   conv_start_o,
  output logic      [1:0]        reference_select_o,
  output logic                   full_scale_o,
  output logic                   dma_empty_req_o,
  output logic                   load_src_cpu_o,
  output logic                   load_src_dma_o,
  output logic                   load_src_buf_o
);
  // ==========================================================================
  // Staging buffer
  logic              fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic              fifo_in_ready;
  wire               buf_write_allowed = !write_protect_i || buffer_protect_bypass_i;
  wire               buf_push_valid    = buf_valid_i && buf_write_allowed && enable_i;
  wire               buf_push          = buf_push_valid && fifo_in_ready;
  wire               start_take        = start_event_i && enable_i;
  wire               buf_pop           = start_take && fifo_out_valid;
  assign buf_ready_o = fifo_in_ready && buf_write_allowed && enable_i;

  dac_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .flush_i     (!enable_i),
    .in_valid_i  (buf_push_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (buf_data_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (start_take),
    .out_data_o  (fifo_out_data)
  );

  // ==========================================================================
  // Sync-ready synchroniser
  logic sync_level;
  logic sync_level_d_r;
  dac_sync3 u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (sync_ready_async_i),
    .level_o   (sync_level)
  );
  wire sync_rise = sync_level && !sync_level_d_r;

  // ==========================================================================
  // Load source selection: buffer copy wins, then DMA, then CPU
  dac_ctrl_pkg::load_src_e src;
  assign src = buf_pop       ? dac_ctrl_pkg::SRC_BUF :
               dma_data_we_i ? dac_ctrl_pkg::SRC_DMA :
               cpu_data_we_i ? dac_ctrl_pkg::SRC_CPU :
                               dac_ctrl_pkg::SRC_NONE;
  wire [DATA_W-1:0] load_data = (src == dac_ctrl_pkg::SRC_BUF) ? fifo_out_data :
                                (src == dac_ctrl_pkg::SRC_DMA) ? dma_data_i :
                                                                 cpu_data_i;
  wire load = (src != dac_ctrl_pkg::SRC_NONE);

  // ==========================================================================
  // Data, conversion start and reference
  logic [DATA_W-1:0] data_r;
  logic              conv_r;
  logic [1:0]        ref_r;
  logic [1:0]        src_r;
  wire  [1:0]        ref_nxt = (reference_select_i == 2'h3) ? ref_r : reference_select_i;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_r <= DATA_W'(dac_ctrl_pkg::DATA_RST);
      conv_r <= 1'b0;
      ref_r  <= dac_ctrl_pkg::REF_RST;
      src_r  <= 2'h0;
    end else begin
      if (load) data_r <= load_data;
      conv_r <= load;
      src_r  <= src;
      if (reference_select_we_i) ref_r <= ref_nxt;
    end
  end
  assign data_o             = data_r;
  assign conv_start_o       = conv_r;
  assign reference_select_o = ref_r;
  assign full_scale_o       = (data_r == DATA_W'(dac_ctrl_pkg::FULL_SCALE));
  assign load_src_cpu_o     = (src_r == 2'(dac_ctrl_pkg::SRC_CPU));
  assign load_src_dma_o     = (src_r == 2'(dac_ctrl_pkg::SRC_DMA));
  assign load_src_buf_o     = (src_r == 2'(dac_ctrl_pkg::SRC_BUF));

  // ==========================================================================
  // DMA empty request
  logic req_r;
  wire  req_set = (buf_pop || !fifo_out_valid) && !buf_push;
  wire  req_clr = buf_push || irq_flag_clear_i[dac_ctrl_pkg::IRQ_EMPTY];
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_r <= 1'b0;
    end else if (!enable_i) begin
      req_r <= 1'b0;
    end else if (req_set) begin
      req_r <= !(irq_flag_clear_i[dac_ctrl_pkg::IRQ_EMPTY] && !buf_pop);
    end else if (req_clr) begin
      req_r <= 1'b0;
    end
  end
  assign dma_empty_req_o = req_r;

  // ==========================================================================
  // Interrupt flags and enables
  logic [2:0] flag_r;
  logic [2:0] en_r;
  wire  [2:0] flag_set;
  assign flag_set[dac_ctrl_pkg::IRQ_EMPTY]    = enable_i && (buf_pop || !fifo_out_valid)
                                                && !buf_push;
  assign flag_set[dac_ctrl_pkg::IRQ_UNDERRUN] = start_take && !fifo_out_valid;
  assign flag_set[dac_ctrl_pkg::IRQ_SYNC_READY_FLAG]  = sync_rise;
  wire  [2:0] flag_nxt = flag_set | (flag_r & ~irq_flag_clear_i);
  wire  [2:0] en_nxt   = irq_enable_set_i | (en_r & ~irq_enable_clear_i);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_r         <= dac_ctrl_pkg::IRQ_RST;
      en_r           <= dac_ctrl_pkg::IRQ_RST;
      sync_level_d_r <= 1'b0;
    end else begin
      flag_r         <= flag_nxt;
      en_r           <= en_nxt;
      sync_level_d_r <= sync_level;
    end
  end
  assign irq_flag_reg_o   = flag_r;
  assign irq_enable_reg_o = en_r;
  assign irq_o            = |(flag_r & en_r);
endmodule // dac_buffer_control
`default_nettype wire

// ===== rtl/dac_ctrl_pkg.sv
// Package: constants shared by the converter control block and its FIFO.
// Assumes a single peripheral clock domain.
package dac_ctrl_pkg;
  // ==========================================================================
  // Widths and reset values
  localparam int          DATA_W        = 10;
  localparam logic [9:0]  DATA_RST      = 10'h000;
  localparam logic [9:0]  FULL_SCALE    = 10'h3ff;
  // ==========================================================================
  // Reference selection codes
  localparam logic [1:0]  REF_INTERNAL  = 2'h0;
  localparam logic [1:0]  REF_ANALOG    = 2'h1;
  localparam logic [1:0]  REF_EXTERNAL  = 2'h2;
  localparam logic [1:0]  REF_RST       = 2'h0;
  // ==========================================================================
  // Interrupt flag positions
  localparam int          IRQ_EMPTY     = 0;
  localparam int          IRQ_UNDERRUN  = 1;
  localparam int          IRQ_SYNC_READY_FLAG   = 2;
  localparam int          IRQ_N         = 3;
  localparam logic [2:0]  IRQ_RST       = 3'h0;
  // ==========================================================================
  // FIFO
  localparam int          FIFO_DEPTH    = 8;
  // ==========================================================================
  // Load source encoding
  typedef enum logic [1:0] {SRC_NONE, SRC_CPU, SRC_DMA, SRC_BUF} load_src_e;
endpackage

// ===== rtl/dac_sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes the input may change at any time relative to sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
module dac_sync3 (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  // Data
  input  wire logic async_i,
  output var  logic level_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule // dac_sync3
`default_nettype wire

// ===== rtl/dac_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; a beat moves when valid and ready are both high.
`timescale 1ns/100ps
`default_nettype none
module dac_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= inc(wr_ptr_r);
      if (pop) rd_ptr_r <= inc(rd_ptr_r);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // dac_fifo
`default_nettype wire

// ===== dv/dac_buffer_control_properties.sv
// Checker: port timing of the converter control block.
// Assumes one clock domain; bound onto every instance.
`timescale 1ns/100ps
`default_nettype none
module dac_buffer_control_properties #(
  parameter int DATA_W = 10
) (
  // Clock and control
  input wire logic              sys_clk_i,
  input wire logic              rstn_i,
  input wire logic              enable_i,
  input wire logic              write_protect_i,
  input wire logic              buffer_protect_bypass_i,
  input wire logic [1:0]        reference_select_i,
  input wire logic              reference_select_we_i,
  // Loads and events
  input wire logic              cpu_data_we_i,
  input wire logic [DATA_W-1:0] cpu_data_i,
  input wire logic              dma_data_we_i,
  input wire logic              buf_valid_i,
  input wire logic              start_event_i,
  input wire logic              sync_ready_async_i,
  input wire logic [2:0]        irq_enable_set_i,
  input wire logic [2:0]        irq_enable_clear_i,
  // Watched outputs
  input wire logic              buf_ready_o,
  input wire logic [2:0]        irq_flag_reg_o,
  input wire logic [2:0]        irq_enable_reg_o,
  input wire logic              irq_o,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic              conv_start_o,
  input wire logic [1:0]        reference_select_o,
  input wire logic              full_scale_o,
  input wire logic              dma_empty_req_o,
  input wire logic              load_src_cpu_o,
  input wire logic              load_src_buf_o
);
  // ====
  // Properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wake;
    $rose(enable_i) && !buf_valid_i;
  endsequence
  sequence s_cpu_only;
    cpu_data_we_i && !dma_data_we_i && !start_event_i;
  endsequence
  AST_CPU_LOAD:
  assert property (s_cpu_only |=> conv_start_o && load_src_cpu_o && data_o == $past(cpu_data_i))
    else $error("cpu load not applied");
  AST_BUF_SRC:
  assert property (load_src_buf_o |-> conv_start_o && $past(start_event_i))
    else $error("buffer load without start");
  AST_FULL:
  assert property (full_scale_o == (data_o == dac_ctrl_pkg::FULL_SCALE))
    else $error("full scale flag wrong");
  AST_WAKE:
  assert property (s_wake |-> ##[1:2] dma_empty_req_o) else $error("no request on enable");
  AST_GUARD:
  assert property (write_protect_i && !buffer_protect_bypass_i |-> !buf_ready_o)
    else $error("protected buffer accepts");
  AST_UNDER:
  assert property (start_event_i && enable_i && !cpu_data_we_i && !dma_data_we_i
    |=> conv_start_o || irq_flag_reg_o[1]) else $error("start neither loads nor underruns");
  AST_IRQ:
  assert property (irq_o == |(irq_flag_reg_o & irq_enable_reg_o)) else $error("irq mismatch");
  AST_EN_SET:
  assert property (irq_enable_set_i != 3'h0 && irq_enable_clear_i == 3'h0
    |=> (irq_enable_reg_o & $past(irq_enable_set_i)) == $past(irq_enable_set_i))
    else $error("enable set lost");
  AST_SYNC:
  assert property ($rose(sync_ready_async_i) |-> ##[1:8] irq_flag_reg_o[2])
    else $error("sync flag late");
  AST_REF:
  assert property (reference_select_we_i && reference_select_i != 2'h3
    |=> reference_select_o == $past(reference_select_i)) else $error("reference not taken");
endmodule // dac_buffer_control_properties
bind dac_buffer_control dac_buffer_control_properties #(.DATA_W(DATA_W)) props (
  .sys_clk_i, .rstn_i, .enable_i, .write_protect_i, .buffer_protect_bypass_i,
  .reference_select_i, .reference_select_we_i, .cpu_data_we_i, .cpu_data_i,
  .dma_data_we_i, .buf_valid_i, .start_event_i, .sync_ready_async_i, .irq_enable_set_i,
  .irq_enable_clear_i, .buf_ready_o, .irq_flag_reg_o, .irq_enable_reg_o, .irq_o, .data_o,
  .conv_start_o, .reference_select_o, .full_scale_o, .dma_empty_req_o, .load_src_cpu_o,
  .load_src_buf_o);
`default_nettype wire

// ===== dv/dac_dma_model.sv
// Model: DMA feeding the staging buffer on request or in bursts.
// Assumes valid is held until ready is sampled high.
`timescale 1ns/100ps
`default_nettype none
module dac_dma_model (
  // Clock and control
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       go_i,
  input  wire logic       burst_i,
  input  wire logic       slow_i,
  // Staging side
  input  wire logic       req_i,
  input  wire logic       ready_i,
  output logic            valid_o,
  output logic      [9:0] data_o
);
  logic [9:0] next_r;
  logic       tick_r;
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_o <= 1'b0;
      data_o  <= 10'h155;
      next_r  <= 10'h001;
      tick_r  <= 1'b0;
    end else begin
      tick_r <= ~tick_r;
      if (valid_o && ready_i) begin
        valid_o <= 1'b0;
        data_o  <= ~data_o;
        next_r  <= next_r + 10'h001;
      end else if (!valid_o && go_i && (req_i || burst_i) && (!slow_i || tick_r)) begin
        valid_o <= 1'b1;
        data_o  <= next_r;
      end
    end
  end
endmodule // dac_dma_model
`default_nettype wire

// ===== dv/test_dac_buffer_control.sv
// Testbench: directed scenarios for the converter control block.
// Assumes the checker is bound and the DMA model feeds the buffer.
`timescale 1ns/100ps
`default_nettype none
module test_dac_buffer_control;
  int n_mismatch = 0;
  int checks_done = 0;
  int i;
  logic sys_clk_i = 1'b0, rstn_i = 1'b0, enable_i = 1'b0, write_protect_i = 1'b0;
  logic buffer_protect_bypass_i = 1'b0, reference_select_we_i = 1'b0, cpu_data_we_i = 1'b0;
  logic dma_data_we_i = 1'b0, start_event_i = 1'b0, sync_ready_async_i = 1'b0;
  logic go = 1'b0, burst = 1'b0, slow = 1'b0;
  logic [1:0] reference_select_i = 2'h0, reference_select_o;
  logic [9:0] cpu_data_i = 10'h000, dma_data_i = 10'h000, buf_data_i, data_o;
  logic [2:0] irq_flag_clear_i = 3'h0, irq_enable_set_i = 3'h0, irq_enable_clear_i = 3'h0;
  logic [2:0] irq_flag_reg_o, irq_enable_reg_o;
  logic buf_valid_i, buf_ready_o, irq_o, conv_start_o, full_scale_o, dma_empty_req_o;
  logic load_src_cpu_o, load_src_dma_o, load_src_buf_o;
  always #2.5 sys_clk_i = ~sys_clk_i;
  dac_buffer_control uut (.sys_clk_i, .rstn_i, .enable_i, .write_protect_i,
    .buffer_protect_bypass_i, .reference_select_i, .reference_select_we_i, .cpu_data_we_i,
    .cpu_data_i, .buf_valid_i, .buf_ready_o, .buf_data_i, .dma_data_we_i, .dma_data_i,
    .start_event_i, .sync_ready_async_i, .irq_flag_clear_i, .irq_enable_set_i,
    .irq_enable_clear_i, .irq_flag_reg_o, .irq_enable_reg_o, .irq_o, .data_o, .conv_start_o,
    .reference_select_o, .full_scale_o, .dma_empty_req_o, .load_src_cpu_o, .load_src_dma_o,
    .load_src_buf_o);
  dac_dma_model feeder (.sys_clk_i, .rstn_i, .go_i(go), .burst_i(burst), .slow_i(slow),
    .req_i(dma_empty_req_o), .ready_i(buf_ready_o), .valid_o(buf_valid_i), .data_o(buf_data_i));
  // ====
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic timeout;
    n_mismatch++;
    stop_test();
  endtask
  // ====
  // Scenarios
  task automatic t_reset;
    chk({data_o, conv_start_o, dma_empty_req_o, buf_ready_o, irq_flag_reg_o}, 16'h0000);
    chk(reference_select_o, dac_ctrl_pkg::REF_RST);
    enable_i = 1'b1;
    cyc(2);
    chk({dma_empty_req_o, irq_flag_reg_o}, 16'h0009);
    $display("reset test done");
  endtask
  task automatic t_irq;
    irq_enable_set_i = 3'h1;
    cyc();
    irq_enable_set_i = 3'h0;
    chk({irq_o, irq_enable_reg_o}, 16'h0009);
    irq_enable_clear_i = 3'h1;
    cyc();
    irq_enable_clear_i = 3'h0;
    chk({irq_o, irq_enable_reg_o}, 16'h0000);
    sync_ready_async_i = 1'b1;
    for (i = 0; i < 8 && irq_flag_reg_o[2] !== 1'b1; i++) cyc();
    if (i == 8) timeout();
    irq_flag_clear_i = 3'h4;
    cyc();
    irq_flag_clear_i = 3'h0;
    chk(irq_flag_reg_o, 16'h0001);
    $display("interrupt test done");
  endtask
  task automatic t_ref;
    reference_select_we_i = 1'b1;
    reference_select_i = dac_ctrl_pkg::REF_EXTERNAL;
    cyc();
    reference_select_i = 2'h3;
    chk(reference_select_o, 16'h0002);
    cyc();
    reference_select_i = dac_ctrl_pkg::REF_ANALOG;
    chk(reference_select_o, 16'h0002);
    cyc();
    reference_select_we_i = 1'b0;
    chk(reference_select_o, 16'h0001);
    $display("reference test done");
  endtask
  task automatic t_load;
    cpu_data_we_i = 1'b1;
    cpu_data_i = 10'h3ff;
    cyc();
    dma_data_we_i = 1'b1;
    dma_data_i = 10'h155;
    cpu_data_i = 10'h0aa;
    chk({full_scale_o, conv_start_o, load_src_cpu_o, data_o}, {3'h7, 10'h3ff});
    cyc();
    cpu_data_we_i = 1'b0;
    dma_data_we_i = 1'b0;
    chk({full_scale_o, conv_start_o, load_src_dma_o, data_o}, {3'h3, 10'h155});
    cyc();
    chk(conv_start_o, 16'h0000);
    $display("load test done");
  endtask
  task automatic t_stage;
    write_protect_i = 1'b1;
    go = 1'b1;
    cyc(3);
    chk({buf_ready_o, dma_empty_req_o}, 16'h0001);
    buffer_protect_bypass_i = 1'b1;
    cyc(3);
    chk(dma_empty_req_o, 16'h0000);
    burst = 1'b1;
    slow = 1'b1;
    for (i = 0; i < 40 && buf_ready_o !== 1'b0; i++) cyc();
    if (i == 40) timeout();
    go = 1'b0;
    burst = 1'b0;
    for (i = 1; i <= 9; i++) begin
      start_event_i = 1'b1;
      cyc();
      start_event_i = 1'b0;
      chk({conv_start_o, dma_empty_req_o, irq_flag_reg_o[1], data_o},
          {i < 9 ? 3'h6 : 3'h3, i < 9 ? i[9:0] : 10'h008});
      cyc();
    end
    $display("staging test done");
  endtask
  initial begin
    cyc(4);
    rstn_i = 1'b1;
    cyc();
    t_reset();
    t_irq();
    t_ref();
    t_load();
    t_stage();
    stop_test();
  end
endmodule // test_dac_buffer_control
`default_nettype wire
